//--- core/cbl_exec.sv
// Execution unit for branches on I, I/O bit ops, shifts, flag ops,
// moves and indirect loads.
// Assumes asynchronous-read data memory and asynchronous-read I/O space.
//
// Function
// - Branch on I set: taken costs two cycles, else one.
// - Branch on I clear: taken costs two cycles, else one.
// - I/O bit set: read-modify-write one bit, no flags, two cycles.
// - I/O bit clear: read-modify-write one bit, no flags, two cycles.
// - Shift left, zero in bit 0, updates Z C N V, one cycle.
// - Shift right, zero in bit 7, updates Z C N V, one cycle.
// - Rotate left through carry, updates Z C N V, one cycle.
// - Rotate right through carry, updates Z C N V, one cycle.
// - Copy selected register bit into T only, one cycle.
// - Copy T into selected register bit, no flags, one cycle.
// - Set or clear S alone in one cycle.
// - Set or clear V, C, N, Z alone in one cycle.
// - Set or clear H and T alone in one cycle.
// - Load at pointer then increment pointer, two cycles, no flags.
// - Decrement pointer then load at it, two cycles, no flags.
// - Load at selected pointer (X, Y or Z) plus displacement, pointer kept, two cycles.
`timescale 1ns/1ps
`include "cbl_map.svh"

module cbl_exec import cbl_pkg::*; #(
   parameter int PC_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Operation issue
   input wire logic op_valid,
   output logic op_ready,
   input wire cbl_op_t op,
   input wire logic [4:0] rd_idx,
   input wire logic [4:0] rr_idx,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] imm,
   input wire logic [6:0] branch_k,
   input wire logic [5:0] io_port,
   input wire logic [5:0] disp_q,
   input wire logic [1:0] ptr_sel,
   // Core state
   output logic [PC_W-1:0] pc,
   output logic [7:0] status_register,
   // Data memory
   output logic mem_rd_en,
   output logic [15:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   // I/O space
   output logic io_rd_en,
   output logic io_wr_en,
   output logic [5:0] io_addr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // Register observation
   input wire logic [4:0] dbg_idx,
   output logic [7:0] dbg_data
);

   //--------------------------------------------------------------
   // Decode helpers
   //--------------------------------------------------------------
   cbl_state_t state;
   logic [7:0] gpr [32];
   logic acc;
   logic is_load;
   logic is_io;
   logic is_shift;
   logic taken;
   logic [7:0] src;
   logic [7:0] srr;
   logic [4:0] plo;
   logic [15:0] ptr;
   logic [15:0] next_addr;
   logic [7:0] sh_res;
   logic sh_c;
   logic [4:0] ld_dst;
   logic io_set;
   logic [7:0] io_mask;
   logic [PC_W-1:0] k_ext;

   assign op_ready = (state == ST_IDLE);
   assign acc = op_valid && op_ready;
   assign is_load = op inside {OP_LOAD_PLAIN, OP_LOAD_POST_INC,
                               OP_LOAD_PRE_DEC, OP_LOAD_DISPLACED};
   assign is_io = op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
   assign is_shift = op inside {OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT,
                                OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
                                OP_ARITH_SHIFT_RIGHT};
   assign src = gpr[rd_idx];
   assign srr = gpr[rr_idx];
   assign k_ext = PC_W'({{(PC_W-7){branch_k[6]}}, branch_k});

   always_comb begin
      taken = 1'b0;
      if (op == OP_BRANCH_ON_IRQ_ENABLED) begin
         taken = status_register[`CBL_FLAG_I];
      end else if (op == OP_BRANCH_ON_IRQ_DISABLED) begin
         taken = !status_register[`CBL_FLAG_I];
      end
   end

   //--------------------------------------------------------------
   // Pointer and address
   //--------------------------------------------------------------
   always_comb begin
      if (ptr_sel == `CBL_SEL_X) begin
         plo = `CBL_PTR_X_LO;
      end else if (ptr_sel == `CBL_SEL_Y) begin
         plo = `CBL_PTR_Y_LO;
      end else begin
         plo = `CBL_PTR_Z_LO;
      end
   end

   assign ptr = {gpr[plo + 5'h01], gpr[plo]};

   always_comb begin
      next_addr = ptr;
      if (op == OP_LOAD_PRE_DEC) begin
         next_addr = ptr - 16'h0001;
      end else if (op == OP_LOAD_DISPLACED) begin
         next_addr = ptr + {10'h000, disp_q};
      end
   end

   //--------------------------------------------------------------
   // Shifter
   //--------------------------------------------------------------
   always_comb begin
      sh_res = src;
      sh_c = 1'b0;
      case (op)
         OP_LOGIC_SHIFT_LEFT: begin
            sh_res = {src[6:0], 1'b0};
            sh_c = src[7];
         end
         OP_LOGIC_SHIFT_RIGHT: begin
            sh_res = {1'b0, src[7:1]};
            sh_c = src[0];
         end
         OP_ROTATE_LEFT_CARRY: begin
            sh_res = {src[6:0], status_register[`CBL_FLAG_C]};
            sh_c = src[7];
         end
         OP_ROTATE_RIGHT_CARRY: begin
            sh_res = {status_register[`CBL_FLAG_C], src[7:1]};
            sh_c = src[0];
         end
         OP_ARITH_SHIFT_RIGHT: begin
            sh_res = {src[7], src[7:1]};
            sh_c = src[0];
         end
         default: begin
            sh_res = src;
            sh_c = 1'b0;
         end
      endcase
   end

   //--------------------------------------------------------------
   // Sequencer
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (acc && taken) begin
                  state <= ST_BRANCH;
               end else if (acc && is_io) begin
                  state <= ST_IO;
               end else if (acc && is_load) begin
                  state <= ST_LOAD;
               end
            end
            ST_BRANCH, ST_IO, ST_LOAD: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc <= '0;
      end else if (acc) begin
         if (taken) begin
            pc <= pc + k_ext + PC_W'(1);
         end else begin
            pc <= pc + PC_W'(1);
         end
      end
   end

   //--------------------------------------------------------------
   // Status register
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_register <= `CBL_STATUS_REGISTER_RST;
      end else if (acc) begin
         if (is_shift) begin
            status_register[`CBL_FLAG_C] <= sh_c;
            status_register[`CBL_FLAG_Z] <= (sh_res == 8'h00);
            status_register[`CBL_FLAG_N] <= sh_res[7];
            status_register[`CBL_FLAG_V] <= sh_res[7] ^ sh_c;
         end else if (op == OP_BIT_TO_TFLAG) begin
            status_register[`CBL_FLAG_T] <= src[bit_sel];
         end else if (op == OP_FLAG_SET) begin
            status_register[bit_sel] <= 1'b1;
         end else if (op == OP_FLAG_CLEAR) begin
            status_register[bit_sel] <= 1'b0;
         end else if (op == OP_GLOBAL_IRQ_ON) begin
            status_register[`CBL_FLAG_I] <= 1'b1;
         end else if (op == OP_GLOBAL_IRQ_OFF) begin
            status_register[`CBL_FLAG_I] <= 1'b0;
         end
      end
   end

   //--------------------------------------------------------------
   // Register file
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 32; i++) begin
            gpr[i] <= `CBL_GPR_RST;
         end
      end else begin
         if (acc) begin
            if (is_shift) begin
               gpr[rd_idx] <= sh_res;
            end
            case (op)
               OP_NIBBLE_SWAP: gpr[rd_idx] <= {src[3:0], src[7:4]};
               OP_TFLAG_TO_BIT: begin
                  gpr[rd_idx][bit_sel] <= status_register[`CBL_FLAG_T];
               end
               OP_MOVE: gpr[rd_idx] <= srr;
               OP_WORD_COPY: begin
                  gpr[{rd_idx[4:1], 1'b0}] <= gpr[{rr_idx[4:1], 1'b0}];
                  gpr[{rd_idx[4:1], 1'b1}] <= gpr[{rr_idx[4:1], 1'b1}];
               end
               OP_LOAD_IMMEDIATE: gpr[rd_idx] <= imm;
               OP_LOAD_POST_INC: begin
                  {gpr[plo + 5'h01], gpr[plo]} <= ptr + 16'h0001;
               end
               OP_LOAD_PRE_DEC: begin
                  {gpr[plo + 5'h01], gpr[plo]} <= ptr - 16'h0001;
               end
               default: begin
               end
            endcase
         end
         // Loaded byte lands last, over any pointer update
         if (state == ST_LOAD) begin
            gpr[ld_dst] <= mem_rdata;
         end
      end
   end

   //--------------------------------------------------------------
   // Data memory and I/O strobes
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_rd_en <= 1'b0;
         mem_addr <= 16'h0000;
         ld_dst <= 5'h00;
      end else begin
         mem_rd_en <= acc && is_load;
         if (acc && is_load) begin
            mem_addr <= next_addr;
            ld_dst <= rd_idx;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         io_rd_en <= 1'b0;
         io_wr_en <= 1'b0;
         io_addr <= 6'h00;
         io_wdata <= 8'h00;
         io_set <= 1'b0;
         io_mask <= 8'h00;
      end else begin
         io_rd_en <= acc && is_io;
         io_wr_en <= (state == ST_IO);
         if (acc && is_io) begin
            io_addr <= io_port;
            io_set <= (op == OP_IO_BIT_SET);
            io_mask <= 8'h01 << bit_sel;
         end
         if (state == ST_IO) begin
            if (io_set) begin
               io_wdata <= io_rdata | io_mask;
            end else begin
               io_wdata <= io_rdata & ~io_mask;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dbg_data <= 8'h00;
      end else begin
         dbg_data <= gpr[dbg_idx];
      end
   end

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence two_slot;
      !op_ready ##1 op_ready;
   endsequence

   a_irq_br_taken: assert property (
      acc && op == OP_BRANCH_ON_IRQ_ENABLED && status_register[`CBL_FLAG_I]
      |=> (pc == $past(pc) + $past(k_ext) + PC_W'(1)) and two_slot)
      else $error("branch on I set not taken in two cycles");

   a_irq_br_fall: assert property (
      acc && op == OP_BRANCH_ON_IRQ_DISABLED && status_register[`CBL_FLAG_I]
      |=> op_ready && pc == $past(pc) + PC_W'(1))
      else $error("branch on I clear did not fall through");

   a_io_set_rmw: assert property (
      acc && op == OP_IO_BIT_SET
      |=> io_rd_en && !op_ready
      ##1 io_wr_en && io_wdata == ($past(io_rdata) | $past(io_mask))
         && status_register == $past(status_register, 2))
      else $error("I/O bit set wrong");

   a_io_clr_rmw: assert property (
      acc && op == OP_IO_BIT_CLEAR |=> two_slot ##0 io_wr_en
         && !io_wdata[$past(bit_sel, 2)])
      else $error("I/O bit clear wrong");

   a_shl_flags: assert property (
      acc && op == OP_LOGIC_SHIFT_LEFT
      |=> op_ready && status_register[`CBL_FLAG_C] == $past(src[7])
         && status_register[`CBL_FLAG_V] ==
            (status_register[`CBL_FLAG_N] ^ status_register[`CBL_FLAG_C]))
      else $error("shift left flags wrong");

   a_rotr_carry: assert property (
      acc && op == OP_ROTATE_RIGHT_CARRY
      |=> status_register[`CBL_FLAG_C] == $past(src[0])
         && status_register[`CBL_FLAG_N] == $past(status_register[`CBL_FLAG_C]))
      else $error("rotate right carry wrong");

   a_tflag_store: assert property (
      acc && op == OP_BIT_TO_TFLAG
      |=> status_register[`CBL_FLAG_T] == $past(src[bit_sel])
         && (status_register & 8'hbf) == ($past(status_register) & 8'hbf))
      else $error("T store wrong");

   a_flag_set_one: assert property (
      acc && op == OP_FLAG_SET
      |=> status_register == ($past(status_register) | (8'h01 << $past(bit_sel))))
      else $error("flag set touched other bits");

   a_ld_post_inc: assert property (
      acc && op == OP_LOAD_POST_INC
      |=> mem_rd_en && mem_addr == $past(ptr) && !op_ready ##1 op_ready)
      else $error("post-increment load wrong");

   a_ld_pre_dec: assert property (
      acc && op == OP_LOAD_PRE_DEC |=> mem_addr == $past(ptr) - 16'h0001)
      else $error("pre-decrement address wrong");

   a_ld_disp_addr: assert property (
      acc && op == OP_LOAD_DISPLACED
      |=> mem_addr == $past(ptr) + {10'h000, $past(disp_q)} && ptr == $past(ptr))
      else $error("displaced load address wrong");

   a_irq_on_only: assert property (
      acc && op == OP_GLOBAL_IRQ_ON
      |=> status_register[`CBL_FLAG_I]
         && status_register[6:0] == $past(status_register[6:0]))
      else $error("interrupt enable touched other bits");

endmodule

//--- core/cbl_map.svh
// Constants of the bit, flag and load execution unit
// Assumes the pointer pairs sit at the top of the register file
`ifndef CBL_MAP_SVH
`define CBL_MAP_SVH
// Status bit positions
`define CBL_FLAG_C 0
`define CBL_FLAG_Z 1
`define CBL_FLAG_N 2
`define CBL_FLAG_V 3
`define CBL_FLAG_S 4
`define CBL_FLAG_H 5
`define CBL_FLAG_T 6
`define CBL_FLAG_I 7
// Low register of each pointer pair
`define CBL_PTR_X_LO 5'h1a
`define CBL_PTR_Y_LO 5'h1c
`define CBL_PTR_Z_LO 5'h1e
// Pointer select codes
`define CBL_SEL_X 2'h0
`define CBL_SEL_Y 2'h1
// Reset values
`define CBL_STATUS_REGISTER_RST 8'h00
`define CBL_GPR_RST 8'h00
`endif

//--- core/cbl_pkg.sv
// Types of the bit, flag and load execution unit
// Assumes the issuing stage hands over already decoded operations
package cbl_pkg;
   typedef enum logic [4:0] {
      OP_NOP,
      OP_BRANCH_ON_IRQ_ENABLED,
      OP_BRANCH_ON_IRQ_DISABLED,
      OP_IO_BIT_SET,
      OP_IO_BIT_CLEAR,
      OP_LOGIC_SHIFT_LEFT,
      OP_LOGIC_SHIFT_RIGHT,
      OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY,
      OP_ARITH_SHIFT_RIGHT,
      OP_NIBBLE_SWAP,
      OP_FLAG_SET,
      OP_FLAG_CLEAR,
      OP_BIT_TO_TFLAG,
      OP_TFLAG_TO_BIT,
      OP_GLOBAL_IRQ_ON,
      OP_GLOBAL_IRQ_OFF,
      OP_MOVE,
      OP_WORD_COPY,
      OP_LOAD_IMMEDIATE,
      OP_LOAD_PLAIN,
      OP_LOAD_POST_INC,
      OP_LOAD_PRE_DEC,
      OP_LOAD_DISPLACED
   } cbl_op_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BRANCH,
      ST_IO,
      ST_LOAD
   } cbl_state_t;
endpackage

//--- sim/cbl_far_model.sv
// Far-side model: data memory and I/O register space
// Assumes strobes and addresses from the execution unit, one clock
`timescale 1ns/1ps

module cbl_far_model (
   // Clock
   input wire logic clk,
   // Data memory
   input wire logic mem_rd_en,
   input wire logic [15:0] mem_addr,
   output logic [7:0] mem_rdata,
   // I/O space
   input wire logic io_rd_en,
   input wire logic io_wr_en,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata
);
   logic [7:0] io_mem [64];
   logic [7:0] mem_last = 8'h00;
   logic [7:0] io_last = 8'h00;

   // Memory contents follow the address
   function automatic logic [7:0] mem_byte(input logic [15:0] a);
      return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5a;
   endfunction

   initial begin
      for (int i = 0; i < 64; i++) begin
         io_mem[i] = 8'(i * 37);
      end
   end

   // Idle bus shows inverted last value
   always_comb mem_rdata = mem_rd_en ? mem_byte(mem_addr) : ~mem_last;
   always_comb io_rdata = io_rd_en ? io_mem[io_addr] : ~io_last;

   always @(posedge clk) begin
      if (mem_rd_en) mem_last <= mem_rdata;
      if (io_rd_en) io_last <= io_rdata;
      if (io_wr_en) io_mem[io_addr] <= io_wdata;
   end
endmodule

//--- sim/tb_cbl_exec.sv
// Self-checking bench of the bit, flag and load execution unit
// Assumes the far-side model for data memory and I/O space
`timescale 1ns/1ps
`include "cbl_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_cbl_exec import cbl_pkg::*; ;
   logic clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, op_ready;
   logic mem_rd_en, io_rd_en, io_wr_en, poke, look;
   cbl_op_t op = OP_NOP;
   logic [4:0] rd_idx = 5'h00, rr_idx = 5'h00, dbg_idx = 5'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [7:0] imm = 8'h00, status_register, mem_rdata, io_wdata, io_rdata, dbg_data, sr;
   logic [6:0] branch_k = 7'h00;
   logic [5:0] io_port = 6'h00, disp_q = 6'h00, io_addr;
   logic [1:0] ptr_sel = 2'h0;
   logic [15:0] pc, mem_addr, epc;
   logic [31:0] u;
   logic [7:0] rf [32];
   int error_cnt = 0, comparisons = 0;

   always #25 clk = ~clk;

   cbl_exec #(.PC_W(16)) i_dut (.clk, .rstn, .op_valid, .op_ready, .op, .rd_idx, .rr_idx,
      .bit_sel, .imm, .branch_k, .io_port, .disp_q, .ptr_sel, .pc, .status_register,
      .mem_rd_en, .mem_addr, .mem_rdata, .io_rd_en, .io_wr_en, .io_addr, .io_wdata,
      .io_rdata, .dbg_idx, .dbg_data);

   cbl_far_model i_far (.clk, .mem_rd_en, .mem_addr, .mem_rdata, .io_rd_en, .io_wr_en,
      .io_addr, .io_wdata, .io_rdata);

   // ----------------------------------------
   // Checking tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk_reg(input logic [4:0] i);
      dbg_idx = i;
      @(negedge clk);
      `CHK("reg", rf[i], dbg_data)
   endtask

   // Reference model, issue and check of one operation
   task automatic run_op(input cbl_op_t o);
      logic [7:0] a, r, ew, m;
      logic [15:0] p, ad;
      logic [4:0] pl;
      logic nc, two, ld, io, sh;
      a = rf[rd_idx];
      r = a;
      nc = sr[`CBL_FLAG_C];
      two = 1'b0;
      pl = ptr_sel == `CBL_SEL_X ? `CBL_PTR_X_LO :
         ptr_sel == `CBL_SEL_Y ? `CBL_PTR_Y_LO : `CBL_PTR_Z_LO;
      p = {rf[pl + 5'h1], rf[pl]};
      ad = p;
      epc = epc + 16'h1;
      `CHK("ready", 1'b1, op_ready)
      op = o;
      op_valid = 1'b1;
      case (o)
         OP_BRANCH_ON_IRQ_ENABLED, OP_BRANCH_ON_IRQ_DISABLED: begin
            two = sr[`CBL_FLAG_I] == (o == OP_BRANCH_ON_IRQ_ENABLED);
            if (two) epc = epc + {{9{branch_k[6]}}, branch_k};
         end
         OP_LOGIC_SHIFT_LEFT: {nc, r} = {a, 1'b0};
         OP_LOGIC_SHIFT_RIGHT: {r, nc} = {1'b0, a};
         OP_ROTATE_LEFT_CARRY: {nc, r} = {a, sr[`CBL_FLAG_C]};
         OP_ROTATE_RIGHT_CARRY: {r, nc} = {sr[`CBL_FLAG_C], a};
         OP_ARITH_SHIFT_RIGHT: {r, nc} = {a[7], a};
         OP_NIBBLE_SWAP: r = {a[3:0], a[7:4]};
         OP_FLAG_SET: sr[bit_sel] = 1'b1;
         OP_FLAG_CLEAR: sr[bit_sel] = 1'b0;
         OP_BIT_TO_TFLAG: sr[`CBL_FLAG_T] = a[bit_sel];
         OP_TFLAG_TO_BIT: r[bit_sel] = sr[`CBL_FLAG_T];
         OP_GLOBAL_IRQ_ON: sr[`CBL_FLAG_I] = 1'b1;
         OP_GLOBAL_IRQ_OFF: sr[`CBL_FLAG_I] = 1'b0;
         OP_MOVE: r = rf[rr_idx];
         OP_WORD_COPY: r = rf[{rr_idx[4:1], rd_idx[0]}];
         OP_LOAD_IMMEDIATE: r = imm;
         OP_LOAD_POST_INC: p = p + 16'h1;
         OP_LOAD_PRE_DEC: {p, ad} = {p - 16'h1, p - 16'h1};
         OP_LOAD_DISPLACED: ad = p + {10'h000, disp_q};
         default: r = a;
      endcase
      sh = o inside {OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
         OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT};
      if (sh) sr[3:0] = {r[7] ^ nc, r[7], r == 8'h00, nc};
      if (o == OP_WORD_COPY) rf[{rd_idx[4:1], ~rd_idx[0]}] = rf[{rr_idx[4:1], ~rd_idx[0]}];
      ld = o inside {OP_LOAD_PLAIN, OP_LOAD_POST_INC, OP_LOAD_PRE_DEC, OP_LOAD_DISPLACED};
      io = o inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
      two = two | ld | io;
      // Pointer first so a loaded byte in the pointer wins
      if (ld) {rf[pl + 5'h1], rf[pl]} = p;
      if (ld) r = i_far.mem_byte(ad);
      rf[rd_idx] = r;
      @(posedge clk);
      @(negedge clk);
      // Offer again while busy; must be ignored
      if (two) op_valid = poke;
      `CHK("ready c1", ~two, op_ready)
      if (ld) `CHK("mem_rd_en", 1'b1, mem_rd_en)
      if (ld) `CHK("mem_addr", ad, mem_addr)
      if (io) `CHK("io_rd_en", 1'b1, io_rd_en)
      if (io) `CHK("io_addr", io_port, io_addr)
      m = 8'h01 << bit_sel;
      ew = o == OP_IO_BIT_SET ? i_far.io_mem[io_port] | m : i_far.io_mem[io_port] & ~m;
      if (two) @(negedge clk);
      // Held high only when the next operation follows at once
      if (look || ld) op_valid = 1'b0;
      if (ld) `CHK("mem_rd_en c2", 1'b0, mem_rd_en)
      if (io) `CHK("io_wr_en", 1'b1, io_wr_en)
      if (io) `CHK("io_wdata", ew, io_wdata)
      `CHK("pc", epc, pc)
      `CHK("status", sr, status_register)
      if (look) chk_reg(rd_idx);
      if (ld) chk_reg(pl);
      if (ld) chk_reg(pl + 5'h1);
   endtask

   task automatic go(input cbl_op_t o, input logic [4:0] d, s, input logic [2:0] b,
      input logic [7:0] x);
      rd_idx = d;
      rr_idx = o == OP_BIT_TO_TFLAG ? d : s;
      bit_sel = b;
      imm = x;
      branch_k = x[6:0];
      io_port = x[5:0];
      disp_q = x[5:0];
      ptr_sel = x[1:0];
      run_op(o);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'ha312d94b));
      sr = 8'h00;
      epc = 16'h0000;
      poke = 1'b1;
      look = 1'b1;
      foreach (rf[i]) rf[i] = 8'h00;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      go(OP_LOAD_PRE_DEC, 5'h02, 5'h00, 3'h0, 8'h00);
      go(OP_LOAD_POST_INC, 5'h1c, 5'h00, 3'h0, 8'h01);
      go(OP_LOAD_DISPLACED, 5'h03, 5'h00, 3'h0, 8'h3e);
      go(OP_LOAD_IMMEDIATE, 5'h10, 5'h00, 3'h0, 8'h80);
      go(OP_ARITH_SHIFT_RIGHT, 5'h10, 5'h00, 3'h0, 8'h00);
      go(OP_LOGIC_SHIFT_LEFT, 5'h10, 5'h00, 3'h0, 8'h00);
      go(OP_ROTATE_RIGHT_CARRY, 5'h10, 5'h00, 3'h0, 8'h00);
      go(OP_ROTATE_LEFT_CARRY, 5'h10, 5'h00, 3'h0, 8'h00);
      go(OP_LOGIC_SHIFT_RIGHT, 5'h02, 5'h00, 3'h0, 8'h00);
      go(OP_NIBBLE_SWAP, 5'h02, 5'h00, 3'h0, 8'h00);
      go(OP_BIT_TO_TFLAG, 5'h02, 5'h00, 3'h7, 8'h00);
      go(OP_TFLAG_TO_BIT, 5'h04, 5'h00, 3'h6, 8'h00);
      go(OP_MOVE, 5'h05, 5'h02, 3'h0, 8'h00);
      go(OP_WORD_COPY, 5'h08, 5'h02, 3'h0, 8'h00);
      for (int s = 0; s < 8; s++) begin
         go(OP_FLAG_SET, 5'h00, 5'h00, 3'(s), 8'h00);
         go(OP_FLAG_CLEAR, 5'h00, 5'h00, 3'(s), 8'h00);
      end
      for (int s = 0; s < 2; s++) begin
         go(s ? OP_GLOBAL_IRQ_ON : OP_GLOBAL_IRQ_OFF, 5'h00, 5'h00, 3'h0, 8'h00);
         go(OP_BRANCH_ON_IRQ_ENABLED, 5'h00, 5'h00, 3'h0, 8'h40);
         go(OP_BRANCH_ON_IRQ_DISABLED, 5'h00, 5'h00, 3'h0, 8'h3f);
      end
      go(OP_IO_BIT_SET, 5'h00, 5'h00, 3'h0, 8'h3f);
      go(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 3'h7, 8'h3f);
      // Reset in mid-run clears pc, flags, strobes and registers
      @(negedge clk);
      rstn = 1'b0;
      @(negedge clk);
      `CHK("pc rst", 16'h0000, pc)
      `CHK("status rst", `CBL_STATUS_REGISTER_RST, status_register)
      `CHK("mem_rd_en rst", 1'b0, mem_rd_en)
      `CHK("io_wr_en rst", 1'b0, io_wr_en)
      `CHK("ready rst", 1'b1, op_ready)
      rstn = 1'b1;
      sr = `CBL_STATUS_REGISTER_RST;
      epc = 16'h0000;
      foreach (rf[i]) rf[i] = `CBL_GPR_RST;
      chk_reg(5'h10);
      chk_reg(5'h1a);
      repeat (400) begin
         u = $urandom;
         poke = u[21];
         look = u[22];
         go(cbl_op_t'(u[27:23] % 5'd23 + 5'd1), u[4:0], u[9:5], u[12:10], u[20:13]);
      end
      wrap_up();
   end

   initial begin
      #1000000;
      error_cnt++;
      wrap_up();
   end
endmodule
